/* rtl/ccmc_pkg.sv */
// Function
// - Automatic select clear: speed comes from the speed field, ratio derived from it.
// - Automatic select set: in slave role speed detected from master clocks per frame, speed field ignored; master role still uses the field.
// - After field changes the generated clocks may be briefly unstable.
// - Slave role after reset stays powered down until master and frame clocks run.
// - De-emphasis for 32, 44.1, 48 kHz works only at normal speed.
// - De-emphasis is held separately for each of four DAC pairs.
// - ADC high-pass filter enable, corner scales with sample rate.
// - Output divide bit set halves the master clock output.
// - Role pin high selects master, low selects slave.
// - Master role drives frame and bit clocks; slave role takes them in.
// - Input pair select bit: one differential, zero single-ended.
// - Output pair select bit: one differential, zero single-ended.
// - Master clock comes from an external input or a crystal oscillator.
// - Power-down pin low powers down and restores all settings to defaults.
package ccmc_pkg;
   // Register byte offsets.
   localparam logic [7:0] CCMC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] CCMC_DEEMP_OFS  = 8'h04;
   localparam logic [7:0] CCMC_ANALOG_OFS = 8'h08;
   localparam logic [7:0] CCMC_STATUS_OFS = 8'h0C;
   // Control register fields.
   localparam int CCMC_AUTO_CLOCK_DETECT_SEL_BIT  = 0;
   localparam int CCMC_SPD_LSB   = 1;
   localparam int CCMC_CKS_LSB   = 3;
   localparam int CCMC_DIV_BIT   = 5;
   localparam int CCMC_HPF_BIT   = 6;
   localparam int CCMC_XTAL_BIT  = 7;
   // Reset values.
   localparam logic [7:0] CCMC_CTRL_RST   = 8'h40;
   localparam logic [7:0] CCMC_DEEMP_RST  = 8'h55;
   localparam logic [5:0] CCMC_ANALOG_RST = 6'h00;
   // Speed codes.
   localparam logic [1:0] CCMC_SPD_NORMAL = 2'h0;
   localparam logic [1:0] CCMC_SPD_DOUBLE = 2'h1;
   localparam logic [1:0] CCMC_SPD_QUAD   = 2'h2;
   // Master clock per frame ratios at each speed.
   localparam logic [11:0] CCMC_RATIO_NORMAL = 12'h200;
   localparam logic [11:0] CCMC_RATIO_DOUBLE = 12'h100;
   localparam logic [11:0] CCMC_RATIO_QUAD   = 12'h080;
   // Bit clock is 64 fs: half a bit period in master clocks is ratio / 128.
   localparam int CCMC_BCLK_SHIFT = 7;
   // Frame clock counts that mark an input as running.
   localparam logic [3:0] CCMC_PRESENT_CNT = 4'h3;
endpackage

/* rtl/ccmc_top.sv */
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module ccmc_top #(
   parameter int CNT_W = 12
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Device pins.
   input  wire logic        powerdown_reset_n,
   input  wire logic        role_master,
   input  wire logic        ext_clock_in,
   input  wire logic        crystal_in,
   output logic             crystal_out,
   input  wire logic        frame_clock_i,
   output logic             frame_clock_o,
   output logic             frame_clock_oe,
   input  wire logic        bit_clock_i,
   output logic             bit_clock_o,
   output logic             bit_clock_oe,
   output logic             master_clk_out_pin,
   // Settings seen by the converter core.
   output logic             core_powered,
   output logic [1:0]       eff_speed,
   output logic [3:0]       deemp_active,
   output logic             hpf_en,
   output logic [1:0]       diff_input_en,
   output logic [3:0]       diff_output_en
);
   // Synchronisers for every pin input; stage one is only read by stage two.
   logic [5:0] s1_q, s2_q, s3_q;
   logic [5:0] pin_raw;
   assign pin_raw = {powerdown_reset_n, role_master, ext_clock_in, crystal_in,
                     frame_clock_i, bit_clock_i};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         s3_q <= 6'h00;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic pd_n, is_master, mclk_rise, fclk_rise, xsel;
   assign pd_n      = s2_q[5];
   assign is_master = s2_q[4];

   // Register state.
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] deemp_q, deemp_d;
   logic [5:0] analog_q, analog_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [1:0]  det_speed_q, det_speed_d, eff_speed_q, eff_speed_d;
   logic        pwr_q, pwr_d;

   assign xsel      = ctrl_q[ccmc_pkg::CCMC_XTAL_BIT];
   assign mclk_rise = xsel ? (s2_q[2] & ~s3_q[2]) : (s2_q[3] & ~s3_q[3]);
   assign fclk_rise = s2_q[1] & ~s3_q[1];

   // APB access: one wait-free answer in the access cycle, unmapped gives error.
   always_comb begin
      ctrl_d    = ctrl_q;
      deemp_d   = deemp_q;
      analog_d  = analog_q;
      prdata_d  = 32'h0000_0000;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         unique case (paddr)
            ccmc_pkg::CCMC_CTRL_OFS: begin
               if (pwrite) ctrl_d = pwdata[7:0];
               prdata_d = {24'h000000, ctrl_q};
            end
            ccmc_pkg::CCMC_DEEMP_OFS: begin
               if (pwrite) deemp_d = pwdata[7:0];
               prdata_d = {24'h000000, deemp_q};
            end
            ccmc_pkg::CCMC_ANALOG_OFS: begin
               if (pwrite) analog_d = pwdata[5:0];
               prdata_d = {26'h0000000, analog_q};
            end
            ccmc_pkg::CCMC_STATUS_OFS: begin
               prdata_d = {26'h0000000, det_speed_q, eff_speed_q, is_master, pwr_q};
            end
            default: pslverr_d = 1'b1;
         endcase
      end
      if (!pd_n) begin
         ctrl_d   = ccmc_pkg::CCMC_CTRL_RST;
         deemp_d  = ccmc_pkg::CCMC_DEEMP_RST;
         analog_d = ccmc_pkg::CCMC_ANALOG_RST;
      end
   end
   // Writes land at the setup edge, one edge before the master sees pready.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= ccmc_pkg::CCMC_CTRL_RST;
         deemp_q   <= ccmc_pkg::CCMC_DEEMP_RST;
         analog_q  <= ccmc_pkg::CCMC_ANALOG_RST;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         deemp_q   <= deemp_d;
         analog_q  <= analog_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Ratio detector: counts master clocks per frame clock period.
   logic [CNT_W-1:0] mcnt_q, mcnt_d, ratio_q, ratio_d;
   logic [3:0]       fcnt_q, fcnt_d;
   always_comb begin
      mcnt_d  = mcnt_q;
      ratio_d = ratio_q;
      fcnt_d  = fcnt_q;
      if (mclk_rise) mcnt_d = mcnt_q + 1'b1;
      if (fclk_rise) begin
         ratio_d = mcnt_q;
         mcnt_d  = '0;
         if (fcnt_q != ccmc_pkg::CCMC_PRESENT_CNT) fcnt_d = fcnt_q + 4'h1;
      end
      if (ratio_q > CNT_W'(ccmc_pkg::CCMC_RATIO_DOUBLE + (ccmc_pkg::CCMC_RATIO_DOUBLE >> 1)))
         det_speed_d = ccmc_pkg::CCMC_SPD_NORMAL;
      else if (ratio_q > CNT_W'(ccmc_pkg::CCMC_RATIO_DOUBLE >> 1)
                         + CNT_W'(ccmc_pkg::CCMC_RATIO_QUAD >> 1))
         det_speed_d = ccmc_pkg::CCMC_SPD_DOUBLE;
      else
         det_speed_d = ccmc_pkg::CCMC_SPD_QUAD;
      eff_speed_d = (ctrl_q[ccmc_pkg::CCMC_AUTO_CLOCK_DETECT_SEL_BIT] && !is_master) ? det_speed_q
                    : ctrl_q[ccmc_pkg::CCMC_SPD_LSB +: 2];
      pwr_d = pd_n && (is_master || (fcnt_q == ccmc_pkg::CCMC_PRESENT_CNT && mcnt_q != '0)
                       || pwr_q);
      if (!pd_n) begin
         fcnt_d = 4'h0;
         mcnt_d = '0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mcnt_q      <= '0;
         ratio_q     <= '0;
         fcnt_q      <= 4'h0;
         det_speed_q <= ccmc_pkg::CCMC_SPD_NORMAL;
         eff_speed_q <= ccmc_pkg::CCMC_SPD_NORMAL;
         pwr_q       <= 1'b0;
      end else begin
         mcnt_q      <= mcnt_d;
         ratio_q     <= ratio_d;
         fcnt_q      <= fcnt_d;
         det_speed_q <= det_speed_d;
         eff_speed_q <= eff_speed_d;
         pwr_q       <= pwr_d;
      end
   end

   // Clock generation in master role, counted in master clock edges.
   // clocks may glitch briefly when fields change; no attempt is made to smooth them.
   logic [CNT_W-1:0] gcnt_q, gcnt_d, half_ratio;
   logic             mdiv_q, mdiv_d, mco_q, mco_d, fo_q, fo_d, bo_q, bo_d, oe_q, oe_d;
   logic             xo_q, xo_d;
   always_comb begin
      unique case (eff_speed_q)
         ccmc_pkg::CCMC_SPD_DOUBLE: half_ratio = CNT_W'(ccmc_pkg::CCMC_RATIO_DOUBLE >> 1);
         ccmc_pkg::CCMC_SPD_QUAD:   half_ratio = CNT_W'(ccmc_pkg::CCMC_RATIO_QUAD >> 1);
         default:                   half_ratio = CNT_W'(ccmc_pkg::CCMC_RATIO_NORMAL >> 1);
      endcase
      gcnt_d = gcnt_q;
      fo_d   = fo_q;
      bo_d   = bo_q;
      mdiv_d = mdiv_q;
      if (mclk_rise) begin
         mdiv_d = ~mdiv_q;
         gcnt_d = (gcnt_q + 1'b1 >= half_ratio) ? '0 : gcnt_q + 1'b1;
         if (gcnt_q + 1'b1 >= half_ratio) fo_d = ~fo_q;
         // bit clock toggles every ratio/128 master clocks.
         if (((gcnt_q + 1'b1) & ((half_ratio >> (ccmc_pkg::CCMC_BCLK_SHIFT - 1)) - 1'b1)) == '0)
            bo_d = ~bo_q;
      end
      // halved or undivided master clock out.
      mco_d = ctrl_q[ccmc_pkg::CCMC_DIV_BIT] ? mdiv_q : s2_q[xsel ? 2 : 3];
      oe_d = is_master && pwr_q;
      xo_d = ~s2_q[2];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcnt_q <= '0;
         mdiv_q <= 1'b0;
         mco_q  <= 1'b0;
         fo_q   <= 1'b0;
         bo_q   <= 1'b0;
         oe_q   <= 1'b0;
         xo_q   <= 1'b0;
      end else begin
         gcnt_q <= gcnt_d;
         mdiv_q <= mdiv_d;
         mco_q  <= mco_d;
         fo_q   <= fo_d;
         bo_q   <= bo_d;
         oe_q   <= oe_d;
         xo_q   <= xo_d;
      end
   end
   assign master_clk_out_pin = mco_q;
   assign frame_clock_o      = fo_q;
   assign bit_clock_o        = bo_q;
   assign frame_clock_oe     = oe_q;
   assign bit_clock_oe       = oe_q;
   assign crystal_out        = xo_q;
   assign core_powered       = pwr_q;
   assign eff_speed          = eff_speed_q;

   // Core settings, registered.
   logic [3:0] dact_q, dact_d;
   logic       hpf_q;
   logic [5:0] ana_q;
   genvar g;
   // de-emphasis only at normal speed, per pair.
   generate
      for (g = 0; g < 4; g++) begin : g_deemp
         assign dact_d[g] = (eff_speed_q == ccmc_pkg::CCMC_SPD_NORMAL)
                            && (deemp_q[2*g +: 2] != 2'h1);
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dact_q <= 4'h0;
         hpf_q  <= 1'b1;
         ana_q  <= 6'h00;
      end else begin
         dact_q <= dact_d;
         hpf_q  <= ctrl_q[ccmc_pkg::CCMC_HPF_BIT];
         ana_q  <= analog_q;
      end
   end
   assign deemp_active   = dact_q;
   assign hpf_en         = hpf_q;
   assign diff_input_en  = ana_q[1:0];
   assign diff_output_en = ana_q[5:2];

   // Pair-select register lands on its outputs one edge later.
   pair_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      diff_input_en == $past(analog_q[1:0]) || !$past(presetn))
      else $error("pair select mismatch");
   // Master role enables pin drive once powered.
   role_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(is_master && pwr_q) |-> frame_clock_oe && bit_clock_oe)
      else $error("frame pins not driven in master role");
   // Frame clock pin never driven in slave role.
   slave_in_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(!is_master) |-> !frame_clock_oe)
      else $error("pin driven in slave role");
   // Power-down pin forces defaults.
   pd_def_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(!pd_n) |-> ctrl_q == ccmc_pkg::CCMC_CTRL_RST)
      else $error("defaults not restored");
   // No power in slave role without clocks.
   slave_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(!is_master && fcnt_q == 4'h0 && !pwr_q) |-> !pwr_q)
      else $error("powered without clocks");
   // Manual speed follows field.
   man_spd_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(!ctrl_q[0]) |-> eff_speed_q == $past(ctrl_q[2:1]))
      else $error("manual speed wrong");
   // Auto speed follows detection in slave role.
   auto_spd_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ctrl_q[0] && !is_master) |-> eff_speed_q == $past(det_speed_q))
      else $error("auto speed wrong");
   // De-emphasis off outside normal speed.
   deemp_ns_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(eff_speed_q != 2'h0) |-> deemp_active == 4'h0)
      else $error("de-emphasis at high speed");
   // Divided output follows the toggle stage.
   mco_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ctrl_q[ccmc_pkg::CCMC_DIV_BIT]) |-> master_clk_out_pin == $past(mdiv_q))
      else $error("divided master clock wrong");
endmodule

/* verification/ccmc_host_model.sv */
`timescale 1ns/1ns
// Audio host: makes the master clock and the frame and bit clocks that a slave consumes.
module ccmc_host_model (
   // Clock and controls.
   input  wire logic        pclk,
   input  wire logic        run,
   input  wire logic [11:0] ratio,
   // Clocks toward the converter.
   output logic             mclk = 1'b0,
   output logic             frame = 1'b0,
   output logic             bitclk = 1'b0
);
   int ph = 0;
   int cnt = 0;
   int nx;

   // locked host clocks
   // All clocks stand still low while stopped, so a slave sees no stale edges.
   always @(posedge pclk) begin
      nx = (cnt + 1) % ratio;
      if (!run) begin
         ph <= 0;
         mclk <= 1'b0;
         frame <= 1'b0;
         bitclk <= 1'b0;
      end else if (ph == 2) begin
         ph <= 0;
         mclk <= !mclk;
         if (!mclk) begin
            cnt <= nx;
            frame <= nx >= ratio / 2;
            bitclk <= nx % (ratio / 64) >= ratio / 128;
         end
      end else begin
         ph <= ph + 1;
      end
   end
endmodule

/* verification/codec_clock_and_mode_control_test.sv */
`timescale 1ns/1ns
module codec_clock_and_mode_control_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pd_n = 1'b1;
   logic        role_master = 1'b0;
   logic        run = 1'b0;
   logic [11:0] ratio = 12'h200;
   logic [2:0]  xcnt = 3'h0;
   logic [31:0] rdq, prdata;
   logic        errq, pready, pslverr, mclk, hframe, hbit, fo, foe, bo, boe, mco, pwr, hpf, xo;
   logic [1:0]  spd, din;
   logic [3:0]  deemp, dout;
   int          fail_count = 0;
   int          check_count = 0;
   int          i;
   // The pins are shared: whoever enables its driver owns the wire.
   wire         frame_w = foe ? fo : hframe;
   wire         bit_w = boe ? bo : hbit;
   wire         crystal_in = xcnt[2];

   // Clock, and a crystal at a rate unlike the host's so the source choice shows.
   initial forever #5 pclk = ~pclk;
   always @(posedge pclk) xcnt <= xcnt + 3'h1;

   ccmc_host_model host (.pclk(pclk), .run(run), .ratio(ratio), .mclk(mclk), .frame(hframe),
      .bitclk(hbit));

   ccmc_top #(.CNT_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .powerdown_reset_n(pd_n), .role_master(role_master),
      .ext_clock_in(mclk), .crystal_in(crystal_in), .crystal_out(xo), .frame_clock_i(frame_w),
      .frame_clock_o(fo), .frame_clock_oe(foe), .bit_clock_i(bit_w), .bit_clock_o(bo),
      .bit_clock_oe(boe), .master_clk_out_pin(mco), .core_powered(pwr), .eff_speed(spd),
      .deemp_active(deemp), .hpf_en(hpf), .diff_input_en(din), .diff_output_en(dout));

   // Verdict and end of run.
   task finish_test;
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; pready, read data and error are taken at the rising edge that ends it.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         check("pready", pready, 1'b1);
         finish_test;
      end
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(what, rdq, exp);
   endtask

   function automatic logic [3:0] val(input int s);
      case (s)
         0: return {3'h0, frame_w};
         1: return {3'h0, bit_w};
         2: return {3'h0, mco};
         3: return {3'h0, pwr};
         5: return {3'h0, xo};
         default: return {2'h0, spd};
      endcase
   endfunction

   // Waits for a level under a bound; a bound that runs out ends the run.
   task wait_for(input int s, input logic [3:0] e, input string what);
      int n;
      for (n = 0; n < 20000 && val(s) !== e; n++) @(negedge pclk);
      check(what, val(s), e);
      if (n == 20000) finish_test;
   endtask

   // The first period after a change may be unsettled, so the second full one is measured.
   task per(input int s, input int exp_p, input string what);
      int n, t2, r;
      logic pv, cur;
      r = 0;
      t2 = 0;
      pv = val(s) == 4'h1;
      for (n = 0; n < 16000 && r < 3; n++) begin
         @(negedge pclk);
         cur = val(s) == 4'h1;
         if (cur && !pv) r++;
         if (cur && !pv && r == 2) t2 = n;
         pv = cur;
      end
      check(what, n - 1 - t2, exp_p);
      if (r < 3) finish_test;
   endtask

   function automatic int rat(input int k);
      return 512 >> k;
   endfunction

   // Main sequence: slave role first, since power-up waits on host clocks.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(ccmc_pkg::CCMC_CTRL_OFS, {24'h0, ccmc_pkg::CCMC_CTRL_RST}, "ctrl");
      rd(ccmc_pkg::CCMC_DEEMP_OFS, {24'h0, ccmc_pkg::CCMC_DEEMP_RST}, "deemp");
      rd(ccmc_pkg::CCMC_ANALOG_OFS, 32'h0, "analog");
      check("hpf_en", hpf, 1'b1);
      apb(1'b1, 8'h10, 32'hFF);
      check("pslverr", errq, 1'b1);
      repeat (2000) @(posedge pclk);
      check("core_powered", pwr, 1'b0);
      run <= 1'b1;
      wait_for(3, 4'h1, "core_powered");
      check("oe", {foe, boe}, 2'h0);
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h42);
      wait_for(4, 4'h1, "eff_speed");
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h43);
      for (i = 0; i < 3; i++) begin
         ratio <= rat(i);
         wait_for(4, i, "auto speed");
      end
      rd(ccmc_pkg::CCMC_STATUS_OFS, 32'h29, "status");
      apb(1'b1, ccmc_pkg::CCMC_ANALOG_OFS, 32'h3F);
      @(posedge pclk);
      check("diff", {dout, din}, 6'h3F);
      apb(1'b1, ccmc_pkg::CCMC_ANALOG_OFS, 32'h16);
      @(posedge pclk);
      check("diff", {dout, din}, 6'h16);
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h0);
      @(posedge pclk);
      check("hpf_en", hpf, 1'b0);
      role_master <= 1'b1;
      repeat (4) @(posedge pclk);
      check("oe", {foe, boe}, 2'h3);
      for (i = 0; i < 3; i++) begin
         apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h40 | (i << 1));
         wait_for(4, i, "eff_speed");
         per(0, rat(i) * 6, "frame period");
         per(1, rat(i) / 64 * 6, "bit period");
      end
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h40);
      per(2, 6, "mclk out");
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h60);
      per(2, 12, "mclk out");
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'hC0);
      per(2, 8, "mclk out");
      per(5, 8, "crystal out");
      apb(1'b1, ccmc_pkg::CCMC_DEEMP_OFS, 32'hE4);
      @(posedge pclk);
      check("deemp", deemp, 4'hD);
      apb(1'b1, ccmc_pkg::CCMC_CTRL_OFS, 32'h42);
      repeat (2) @(posedge pclk);
      check("deemp", deemp, 4'h0);
      pd_n <= 1'b0;
      repeat (4) @(posedge pclk);
      check("core_powered", pwr, 1'b0);
      pd_n <= 1'b1;
      rd(ccmc_pkg::CCMC_CTRL_OFS, {24'h0, ccmc_pkg::CCMC_CTRL_RST}, "ctrl");
      rd(ccmc_pkg::CCMC_DEEMP_OFS, {24'h0, ccmc_pkg::CCMC_DEEMP_RST}, "deemp");
      finish_test;
   end
endmodule
